// ==== design/uartmd_params.svh ====
`ifndef UARTMD_PARAMS_SVH
`define UARTMD_PARAMS_SVH

// Register byte addresses
`define UARTMD_ADDR_EFC 12'h000
`define UARTMD_ADDR_MCTL 12'h004
`define UARTMD_ADDR_ENH 12'h008
`define UARTMD_ADDR_MATCH 12'h00C
`define UARTMD_ADDR_INTEN 12'h010
`define UARTMD_ADDR_STAT 12'h014

// extra_features_control fields
`define UARTMD_EFC_IRQ 7
`define UARTMD_EFC_RTSINV 5
`define UARTMD_EFC_DIRCON 4
`define UARTMD_EFC_TXOFF 2
`define UARTMD_EFC_RXOFF 1
`define UARTMD_EFC_MDROP 0
`define UARTMD_EFC_WMASK 8'hB7

// Other control fields
`define UARTMD_MCTL_RTS 1
`define UARTMD_ENH_SCD 5
`define UARTMD_INTEN_LSI 2

// Status fields
`define UARTMD_STAT_RXON 0
`define UARTMD_STAT_TXPEND 1
`define UARTMD_STAT_RTS 2
`define UARTMD_STAT_FLUSH 3

// Reset values
`define UARTMD_EFC_RST 8'h00
`define UARTMD_MCTL_RST 8'h00
`define UARTMD_ENH_RST 8'h00
`define UARTMD_MATCH_RST 8'h00
`define UARTMD_INTEN_RST 8'h00

`endif

// ==== design/uartmd_pkg.sv ====
package uartmd_pkg;

  typedef struct packed {
    logic [7:0] efc;
    logic [7:0] mctl;
    logic [7:0] enh;
    logic [7:0] match;
    logic [7:0] int_en;
    logic tx_pending;
    logic rts_n;
    logic rx_off_prev;
    logic flush_wait;
    logic [31:0] prdata;
  } uartmd_ctrl_type;

  typedef struct packed {
    logic push;
    logic [7:0] data;
    logic perr;
    logic lsi;
    logic en_set;
    logic en_clr;
  } uartmd_filt_type;

endpackage

// ==== design/uartmd_rx_filter.sv ====
`timescale 1ns/10ps
module uartmd_rx_filter #(
  parameter int CHAR_W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [CHAR_W-1:0] i_char,
  input wire logic i_ninth,
  input wire logic i_mdrop,
  input wire logic i_scd,
  input wire logic i_rx_on,
  input wire logic i_lsi_en,
  input wire logic [CHAR_W-1:0] i_match,
  output logic o_push,
  output logic [7:0] o_data,
  output logic o_perr,
  output logic o_lsi,
  output logic o_en_set,
  output logic o_en_clr
);

  if (CHAR_W < 5 || CHAR_W > 8) begin : g_bad_width
    $error("CHAR_W must lie between 5 and 8");
  end

  uartmd_pkg::uartmd_filt_type s;
  uartmd_pkg::uartmd_filt_type next_s;

  always_comb begin
    next_s = '0;
    next_s.data = 8'(i_char);
    if (i_valid) begin
      if (!i_mdrop) begin
        next_s.push = i_rx_on;
      end else if (!i_scd) begin
        if (i_ninth) begin
          next_s.push = 1'b1;
          next_s.perr = 1'b1;
          next_s.lsi = i_lsi_en;
        end else begin
          next_s.push = i_rx_on;
        end
      end else if (i_ninth) begin
        if (i_char == i_match) begin
          next_s.push = 1'b1;
          next_s.perr = i_ninth;
          next_s.lsi = i_lsi_en;
          next_s.en_set = 1'b1;
        end else begin
          next_s.en_clr = 1'b1;
        end
      end else begin
        next_s.push = i_rx_on;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_push = s.push;
  assign o_data = s.data;
  assign o_perr = s.perr;
  assign o_lsi = s.lsi;
  assign o_en_set = s.en_set;
  assign o_en_clr = s.en_clr;

endmodule // uartmd_rx_filter

// ==== design/uartmd_ctrl.sv ====
// Operation
// - Bit 7 picks quarter or 3/16 IR pulse
// - Direction RTS low sending, high receiving; invertible
// - Direction enable hands RTS to transmitter
// - Transmit off after current character; FIFO fills
// - Receive off at once; shift contents flushed
// - Bit 0 selects nine-bit multidrop mode
// - Direction control overrides modem and flow RTS
// - RTS low on write, high after last bit
// - Inverted: RTS high while pending, low after
// - Ninth bit one marks address, interrupts controller
// - Disabled receiver drops data, flags and stores addresses
// - Enabled receiver stores data, flags each address
// - Auto mode discards unmatched addresses, and data while the receiver is disabled
// - Matched address enables receiver, stored with flag
// - Later unmatched address disables receiver, is dropped
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "uartmd_params.svh"
module uartmd_ctrl (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_TX_FIFO_WRITE,
  input wire logic I_TX_FIFO_EMPTY,
  input wire logic I_TX_CHAR_DONE,
  input wire logic I_RX_BUSY,
  input wire logic I_RX_CHAR_VALID,
  input wire logic [7:0] I_RX_CHAR,
  input wire logic I_RX_NINTH,
  input wire logic I_FLOW_EN,
  input wire logic I_FLOW_RTS_N,
  output logic O_RTS_N,
  output logic O_TX_START_OK,
  output logic O_RX_SAMPLE_EN,
  output logic O_RX_FLUSH,
  output logic O_RX_PUSH,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_PAR_FLAG,
  output logic O_LINE_STATUS_EVENT,
  output logic O_IR_QUARTER_PULSE,
  output logic O_MULTIDROP
);

  ////////////////////////////////////////////////////////////////////////////////
  // State

  localparam uartmd_pkg::uartmd_ctrl_type RST_STATE = '{
    efc: `UARTMD_EFC_RST,
    mctl: `UARTMD_MCTL_RST,
    enh: `UARTMD_ENH_RST,
    match: `UARTMD_MATCH_RST,
    int_en: `UARTMD_INTEN_RST,
    tx_pending: 1'b0,
    rts_n: 1'b1,
    rx_off_prev: 1'b0,
    flush_wait: 1'b0,
    prdata: 32'h00000000
  };

  uartmd_pkg::uartmd_ctrl_type s;
  uartmd_pkg::uartmd_ctrl_type next_s;

  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic wr_en;
  logic efc_wr;
  logic rx_on;
  logic f_push;
  logic [7:0] f_data;
  logic f_perr;
  logic f_lsi;
  logic f_en_set;
  logic f_en_clr;
  logic [31:0] rd_mux;

  assign setup_ph = I_PSEL && !I_PENABLE;
  assign access_ph = I_PSEL && I_PENABLE;
  assign wr_en = access_ph && I_PWRITE && mapped;
  assign efc_wr = wr_en && (I_PADDR == `UARTMD_ADDR_EFC);
  // Normal mode still accepts the character caught by a flush
  assign rx_on = !s.efc[`UARTMD_EFC_RXOFF] || s.flush_wait;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read decode

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (I_PADDR)
      `UARTMD_ADDR_EFC: rd_mux[7:0] = s.efc;
      `UARTMD_ADDR_MCTL: rd_mux[7:0] = s.mctl;
      `UARTMD_ADDR_ENH: rd_mux[7:0] = s.enh;
      `UARTMD_ADDR_MATCH: rd_mux[7:0] = s.match;
      `UARTMD_ADDR_INTEN: rd_mux[7:0] = s.int_en;
      `UARTMD_ADDR_STAT: begin
        rd_mux[`UARTMD_STAT_RXON] = O_RX_SAMPLE_EN;
        rd_mux[`UARTMD_STAT_TXPEND] = s.tx_pending;
        rd_mux[`UARTMD_STAT_RTS] = s.rts_n;
        rd_mux[`UARTMD_STAT_FLUSH] = s.flush_wait;
      end
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;
    if (setup_ph) begin
      next_s.prdata = rd_mux;
    end
    if (wr_en) begin
      case (I_PADDR)
        `UARTMD_ADDR_EFC: next_s.efc = I_PWDATA[7:0] & `UARTMD_EFC_WMASK;
        `UARTMD_ADDR_MCTL: next_s.mctl = I_PWDATA[7:0];
        `UARTMD_ADDR_ENH: next_s.enh = I_PWDATA[7:0];
        `UARTMD_ADDR_MATCH: next_s.match = I_PWDATA[7:0];
        `UARTMD_ADDR_INTEN: next_s.int_en = I_PWDATA[7:0];
        default: next_s.int_en = s.int_en;
      endcase
    end
    // Receiver self-enable and self-disable outrank a software write
    if (f_en_set) begin
      next_s.efc[`UARTMD_EFC_RXOFF] = 1'b0;
    end
    if (f_en_clr) begin
      next_s.efc[`UARTMD_EFC_RXOFF] = 1'b1;
    end
    next_s.rx_off_prev = s.efc[`UARTMD_EFC_RXOFF];
    if (I_RX_CHAR_VALID) begin
      next_s.flush_wait = 1'b0;
    end
    if (s.efc[`UARTMD_EFC_RXOFF] && !s.rx_off_prev && !s.efc[`UARTMD_EFC_MDROP]
        && I_RX_BUSY) begin
      next_s.flush_wait = 1'b1;
    end
    if (I_TX_CHAR_DONE && I_TX_FIFO_EMPTY) begin
      next_s.tx_pending = 1'b0;
    end
    if (I_TX_FIFO_WRITE) begin
      next_s.tx_pending = 1'b1;
    end
    if (next_s.efc[`UARTMD_EFC_DIRCON]) begin
      next_s.rts_n = next_s.tx_pending ~^ next_s.efc[`UARTMD_EFC_RTSINV];
    end else if (I_FLOW_EN) begin
      next_s.rts_n = I_FLOW_RTS_N;
    end else begin
      next_s.rts_n = !next_s.mctl[`UARTMD_MCTL_RTS];
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive filter

  uartmd_rx_filter #(
    .CHAR_W(8)
  ) uartmd_rx_filter_i (
    .i_mclk(I_MCLK),
    .i_rst(I_RST),
    .i_valid(I_RX_CHAR_VALID),
    .i_char(I_RX_CHAR),
    .i_ninth(I_RX_NINTH),
    .i_mdrop(s.efc[`UARTMD_EFC_MDROP]),
    .i_scd(s.enh[`UARTMD_ENH_SCD]),
    .i_rx_on(rx_on),
    .i_lsi_en(s.int_en[`UARTMD_INTEN_LSI]),
    .i_match(s.match),
    .o_push(f_push),
    .o_data(f_data),
    .o_perr(f_perr),
    .o_lsi(f_lsi),
    .o_en_set(f_en_set),
    .o_en_clr(f_en_clr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_PRDATA = s.prdata;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = access_ph && !mapped;
  assign O_RTS_N = s.rts_n;
  assign O_TX_START_OK = !s.efc[`UARTMD_EFC_TXOFF];
  // Multidrop keeps sampling so addresses are still seen
  assign O_RX_SAMPLE_EN = !s.efc[`UARTMD_EFC_RXOFF] || s.efc[`UARTMD_EFC_MDROP];
  assign O_RX_FLUSH = s.flush_wait;
  assign O_RX_PUSH = f_push;
  assign O_RX_DATA = f_data;
  assign O_RX_PAR_FLAG = f_perr;
  assign O_LINE_STATUS_EVENT = f_lsi;
  assign O_IR_QUARTER_PULSE = s.efc[`UARTMD_EFC_IRQ];
  assign O_MULTIDROP = s.efc[`UARTMD_EFC_MDROP];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);

  logic dir_plain;
  logic dir_inv;
  logic auto_md;
  logic soft_md;
  assign dir_plain = s.efc[`UARTMD_EFC_DIRCON] && !s.efc[`UARTMD_EFC_RTSINV] && !efc_wr;
  assign dir_inv = s.efc[`UARTMD_EFC_DIRCON] && s.efc[`UARTMD_EFC_RTSINV] && !efc_wr;
  assign auto_md = s.efc[`UARTMD_EFC_MDROP] && s.enh[`UARTMD_ENH_SCD] && I_RX_CHAR_VALID;
  assign soft_md = s.efc[`UARTMD_EFC_MDROP] && !s.enh[`UARTMD_ENH_SCD] && I_RX_CHAR_VALID;

  property p_ir_mode;
    efc_wr |=> O_IR_QUARTER_PULSE == $past(I_PWDATA[7]);
  endproperty
  a_ir_mode: assert property (p_ir_mode) else $error("IR pulse select wrong");

  property p_rts_assert;
    dir_plain && I_TX_FIFO_WRITE |=> !O_RTS_N;
  endproperty
  a_rts_assert: assert property (p_rts_assert) else $error("RTS not low on write");

  property p_rts_release;
    dir_plain && s.tx_pending && I_TX_CHAR_DONE && I_TX_FIFO_EMPTY && !I_TX_FIFO_WRITE
      |=> O_RTS_N;
  endproperty
  a_rts_release: assert property (p_rts_release) else $error("RTS not released");

  property p_rts_inv;
    dir_inv && I_TX_FIFO_WRITE |=> O_RTS_N ##1 (efc_wr || I_TX_CHAR_DONE || O_RTS_N);
  endproperty
  a_rts_inv: assert property (p_rts_inv) else $error("Inverted RTS wrong");

  property p_rts_flow;
    !s.efc[`UARTMD_EFC_DIRCON] && !efc_wr && I_FLOW_EN |=> O_RTS_N == $past(I_FLOW_RTS_N);
  endproperty
  a_rts_flow: assert property (p_rts_flow) else $error("RTS source wrong");

  property p_tx_off;
    efc_wr && I_PWDATA[`UARTMD_EFC_TXOFF] |=> !O_TX_START_OK;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("Transmitter not stopped");

  property p_rx_off;
    efc_wr && I_PWDATA[`UARTMD_EFC_RXOFF] && !I_PWDATA[`UARTMD_EFC_MDROP] && !f_en_set
      |=> !O_RX_SAMPLE_EN;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("Receiver not stopped");

  property p_rx_flush;
    efc_wr && I_PWDATA[`UARTMD_EFC_RXOFF] && !I_PWDATA[`UARTMD_EFC_MDROP] && !f_en_set
      && !s.efc[`UARTMD_EFC_RXOFF] ##1 I_RX_BUSY |=> O_RX_FLUSH;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("Partial character not flushed");

  property p_soft_drop;
    soft_md && !I_RX_NINTH && s.efc[`UARTMD_EFC_RXOFF] |=> !O_RX_PUSH;
  endproperty
  a_soft_drop: assert property (p_soft_drop) else $error("Data kept while off");

  property p_soft_addr;
    soft_md && I_RX_NINTH |=> O_RX_PUSH && O_RX_PAR_FLAG
      && (O_LINE_STATUS_EVENT == $past(s.int_en[`UARTMD_INTEN_LSI]));
  endproperty
  a_soft_addr: assert property (p_soft_addr) else $error("Address not flagged");

  property p_auto_miss;
    auto_md && I_RX_NINTH && I_RX_CHAR != s.match |=> !O_RX_PUSH
      ##1 s.efc[`UARTMD_EFC_RXOFF];
  endproperty
  a_auto_miss: assert property (p_auto_miss) else $error("Unmatched address kept");

  property p_auto_hit;
    auto_md && I_RX_NINTH && I_RX_CHAR == s.match |=> O_RX_PUSH && O_RX_PAR_FLAG
      ##1 !s.efc[`UARTMD_EFC_RXOFF];
  endproperty
  a_auto_hit: assert property (p_auto_hit) else $error("Matched address lost");

  property p_auto_data;
    auto_md && !I_RX_NINTH && s.efc[`UARTMD_EFC_RXOFF] |=> !O_RX_PUSH;
  endproperty
  a_auto_data: assert property (p_auto_data) else $error("Data kept while off");

  c_dir_cycle: cover property (dir_plain && I_TX_FIFO_WRITE ##[1:200] O_RTS_N);
  c_auto_hit: cover property (auto_md && I_RX_NINTH && I_RX_CHAR == s.match);
  c_flush: cover property (O_RX_FLUSH ##[1:200] O_RX_PUSH);

endmodule // uartmd_ctrl

// ==== testbench/uartmd_line_model.sv ====
`timescale 1ns/10ps
module uartmd_line_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_send,
  input wire logic [7:0] i_char,
  input wire logic i_ninth,
  output logic o_valid,
  output logic [7:0] o_char,
  output logic o_ninth,
  output logic o_busy
);
  logic [3:0] cnt;
  logic [8:0] frame;
  ////////////////////////////////////////////////////////////////
  // Remote station frames one nine-bit character per request
  always @(posedge i_mclk) begin
    if (i_rst) begin
      cnt <= 4'h0;
      o_busy <= 1'b0;
      o_valid <= 1'b0;
      frame <= 9'h000;
      {o_ninth, o_char} <= 9'h0A5;
    end else if (i_send && !o_busy) begin
      frame <= {i_ninth, i_char};
      o_busy <= 1'b1;
      o_valid <= 1'b0;
      cnt <= 4'hB;
      {o_ninth, o_char} <= ~{o_ninth, o_char};
    end else if (o_busy && cnt == 4'h1) begin
      o_busy <= 1'b0;
      o_valid <= 1'b1;
      {o_ninth, o_char} <= frame;
    end else begin
      // Lines invert every cycle outside the valid cycle
      o_valid <= 1'b0;
      cnt <= cnt - 4'h1;
      {o_ninth, o_char} <= ~{o_ninth, o_char};
    end
  end
endmodule // uartmd_line_model

// ==== testbench/uart_rs485_multidrop_control_bench.sv ====
`timescale 1ns/10ps
`include "uartmd_params.svh"
module uart_rs485_multidrop_control_bench;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic txw = 1'b0, txe = 1'b1, txd = 1'b0, flen = 1'b0, flrts = 1'b1, snd = 1'b0, sn = 1'b0;
  logic [7:0] sch = 8'h00, ch, rdat;
  logic pready, pslverr, rts_n, txok, samp, flush, push, pflag, lse, irq, md, vld, busy, nin;
  int num_errors = 0, check_count = 0, cycles = 0;

  uartmd_ctrl uartmd_ctrl_i (.I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_TX_FIFO_WRITE(txw), .I_TX_FIFO_EMPTY(txe), .I_TX_CHAR_DONE(txd),
    .I_RX_BUSY(busy), .I_RX_CHAR_VALID(vld), .I_RX_CHAR(ch), .I_RX_NINTH(nin),
    .I_FLOW_EN(flen), .I_FLOW_RTS_N(flrts), .O_RTS_N(rts_n), .O_TX_START_OK(txok),
    .O_RX_SAMPLE_EN(samp), .O_RX_FLUSH(flush), .O_RX_PUSH(push), .O_RX_DATA(rdat),
    .O_RX_PAR_FLAG(pflag), .O_LINE_STATUS_EVENT(lse), .O_IR_QUARTER_PULSE(irq),
    .O_MULTIDROP(md));
  uartmd_line_model uartmd_line_model_i (.i_mclk(clk), .i_rst(rst), .i_send(snd),
    .i_char(sch), .i_ninth(sn), .o_valid(vld), .o_char(ch), .o_ninth(nin), .o_busy(busy));

  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, x, what);
  endtask

  task automatic rx(input logic [7:0] c, input logic n, input logic p, input logic f,
                    input logic l);
    @(posedge clk);
    snd <= 1'b1;
    sch <= c;
    sn <= n;
    @(posedge clk);
    snd <= 1'b0;
    do @(posedge clk); while (vld !== 1'b1);
    #1;
    check(push, p, "push");
    check(lse, l, "lse");
    if (p) begin
      check(rdat, c, "data");
      check(pflag, f, "flag");
    end
  endtask

  task automatic tx(input logic w, input logic d, input logic e, input logic r);
    @(posedge clk);
    txw <= w;
    txd <= d;
    txe <= e;
    @(posedge clk);
    txw <= 1'b0;
    txd <= 1'b0;
    #1;
    check(rts_n, r, "rts");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    check(rts_n, 1'b1, "rts rst");
    check(samp, 1'b1, "samp rst");
    rd(`UARTMD_ADDR_EFC, 32'h0, "efc rst");
    wr(`UARTMD_ADDR_EFC, 32'hFF);
    rd(`UARTMD_ADDR_EFC, 32'hB7, "efc");
    check(irq, 1'b1, "ir");
    check(md, 1'b1, "md");
    check(txok, 1'b0, "txoff");
    wr(`UARTMD_ADDR_EFC, 32'h06);
    check(samp, 1'b0, "rxoff");
    check({irq, md}, 2'h0, "ir md");
    wr(`UARTMD_ADDR_EFC, 32'h00);
    check({samp, txok}, 2'h3, "on");
    apb(1'b1, 12'h018, 32'hFF, r, e);
    check(e, 1'b1, "slverr");
    rd(12'h018, 32'h0, "unmapped");
    $display("register test done");
  endtask

  task automatic t_rts;
    wr(`UARTMD_ADDR_MCTL, 32'h02);
    check(rts_n, 1'b0, "mctl");
    @(posedge clk);
    flen <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(rts_n, 1'b1, "flow");
    @(posedge clk);
    flen <= 1'b0;
    wr(`UARTMD_ADDR_EFC, 32'h10);
    check(rts_n, 1'b1, "dir idle");
    tx(1'b1, 1'b0, 1'b0, 1'b0);
    tx(1'b0, 1'b1, 1'b0, 1'b0);
    tx(1'b0, 1'b1, 1'b1, 1'b1);
    wr(`UARTMD_ADDR_EFC, 32'h30);
    check(rts_n, 1'b0, "inv idle");
    tx(1'b1, 1'b0, 1'b0, 1'b1);
    tx(1'b0, 1'b1, 1'b1, 1'b0);
    wr(`UARTMD_ADDR_EFC, 32'h00);
    check(rts_n, 1'b0, "no dir");
    wr(`UARTMD_ADDR_MCTL, 32'h00);
    $display("rts test done");
  endtask

  task automatic t_multidrop;
    wr(`UARTMD_ADDR_ENH, 32'h00);
    wr(`UARTMD_ADDR_INTEN, 32'h04);
    wr(`UARTMD_ADDR_EFC, 32'h03);
    rx(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(8'h42, 1'b1, 1'b1, 1'b1, 1'b1);
    wr(`UARTMD_ADDR_EFC, 32'h01);
    rx(8'h77, 1'b0, 1'b1, 1'b0, 1'b0);
    rx(8'h99, 1'b1, 1'b1, 1'b1, 1'b1);
    wr(`UARTMD_ADDR_ENH, 32'h20);
    wr(`UARTMD_ADDR_MATCH, 32'h5A);
    wr(`UARTMD_ADDR_INTEN, 32'h00);
    wr(`UARTMD_ADDR_EFC, 32'h03);
    rx(8'h33, 1'b1, 1'b0, 1'b0, 1'b0);
    rx(8'h44, 1'b0, 1'b0, 1'b0, 1'b0);
    rx(8'h5A, 1'b1, 1'b1, 1'b1, 1'b0);
    rd(`UARTMD_ADDR_EFC, 32'h01, "auto on");
    rx(8'h44, 1'b0, 1'b1, 1'b0, 1'b0);
    rx(8'h33, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(`UARTMD_ADDR_EFC, 32'h03, "auto off");
    rx(8'h5A, 1'b1, 1'b1, 1'b1, 1'b0);
    wr(`UARTMD_ADDR_EFC, 32'h00);
    rx(8'h81, 1'b1, 1'b1, 1'b0, 1'b0);
    $display("multidrop test done");
  endtask

  task automatic t_flush;
    @(posedge clk);
    snd <= 1'b1;
    sch <= 8'hC3;
    sn <= 1'b0;
    @(posedge clk);
    snd <= 1'b0;
    // Receive off lands while the character is still arriving
    wr(`UARTMD_ADDR_EFC, 32'h02);
    check(samp, 1'b0, "rx stop");
    @(posedge clk);
    #1;
    check(flush, 1'b1, "flush");
    do @(posedge clk); while (vld !== 1'b1);
    #1;
    check({push, rdat, flush}, {1'b1, 8'hC3, 1'b0}, "flushed char");
    rd(`UARTMD_ADDR_STAT, 32'h4, "stat");
    rx(8'h3C, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(`UARTMD_ADDR_EFC, 32'h00);
    $display("flush test done");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_regs;
    t_rts;
    t_multidrop;
    t_flush;
    report_and_stop;
  end
endmodule // uart_rs485_multidrop_control_bench
